// ===== logic/ucf_channel.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "ucf_map.svh"
// Operation
// - Separate 64-deep queues; receive entries carry errors.
// - Five to eight data bits both ways.
// - Even, odd or no parity; 1/1.5/2 stops.
// - Flag break, idle, framing, overrun, parity.
// - Report transmit queue running dry.
// - Sixteen-bit baud divisor, one to maximum.
// - Prescale select divides reference by four.
// - Three samples per bit, majority vote.
// - Optional queueing; otherwise single character hold.
// - After reset queues off, trigger one.
// - Thresholds selectable or programmed, independent each way.
// - Drive receive and transmit DMA request outputs.
// - Two bits enable auto CTS and RTS.
// - Auto CTS: start character only if active.
// - Auto RTS drops at halt fill level.
// - Auto RTS returns at resume fill level.
// - Accept one extra character after RTS drops.
// - Without auto CTS, send regardless of CTS.
// - No CTS change events under auto CTS.
module ucf_channel #(
	parameter int FIFO_DEPTH = `UCF_FIFO_DEPTH
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire ucf_pkg::ucf_addr_t paddr,
	input  wire ucf_pkg::ucf_word_t pwdata,
	output ucf_pkg::ucf_word_t      prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rxd,
	output logic                   txd,
	input  wire logic              cts_n,
	output logic                   rts_n,
	output logic                   rx_dma_request,
	output logic                   tx_dma_request
);
	import ucf_pkg::*;

	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int CW = AW + 1;

	// Thresholds up to sixty characters need at least the documented depth.
	if (FIFO_DEPTH < `UCF_FIFO_DEPTH || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
		$error("FIFO_DEPTH must be a power of two no smaller than the default.");
	end

	// Expected parity bit for a character; unused upper bits are zero.
	function automatic logic par_of(input logic [7:0] d, input logic even);
		par_of = (^d) ^ ~even;
	endfunction

	// Majority of three samples.
	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	// Effective trigger level: one when queueing is off, else programmed or selected.
	function automatic logic [CW-1:0] trig_lvl(input logic en, input logic [1:0] sel,
			input logic [3:0] prog, input logic rx);
		logic [6:0] pick;
		pick = rx ? ((sel == 2'h0) ? `UCF_RX_TRIG0 : (sel == 2'h1) ? `UCF_RX_TRIG1 :
			(sel == 2'h2) ? `UCF_RX_TRIG2 : `UCF_RX_TRIG3) :
			((sel == 2'h0) ? `UCF_TX_TRIG0 : (sel == 2'h1) ? `UCF_TX_TRIG1 :
			(sel == 2'h2) ? `UCF_TX_TRIG2 : `UCF_TX_TRIG3);
		if (!en) trig_lvl = CW'(1);
		else if (prog != 4'h0) trig_lvl = CW'({prog, 2'h0});
		else trig_lvl = CW'(pick);
	endfunction

	logic [2:0]  rx_sy_q, cts_sy_q;
	logic        rx_f_q, cts_n_f_q;
	logic        pready_q, pslverr_q;
	ucf_word_t   prdata_q;
	logic [4:0]  line_q;
	logic [7:0]  fset_q, pthr_q, flow_q, efr_q, mctl_q;
	logic [15:0] div_q, div_cnt_q;
	logic [1:0]  pre_q;
	logic [6:0]  flags_q;
	logic        rts_n_q, txd_q, rx_dma_q, tx_dma_q;
	logic [AW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
	logic [CW-1:0] rx_cnt_q, tx_cnt_q;
	ucf_rx_st_t  rx_st_q, rx_st_d;
	ucf_tx_st_t  tx_st_q, tx_st_d;
	logic [3:0]  rx_sub_q, tx_sub_q;
	logic [2:0]  rx_bit_q, tx_bit_q, vote_q;
	logic [7:0]  rx_sh_q, tx_sh_q;
	logic        rx_perr_q, tx_par_q, tx_cts_q;
	logic [1:0]  tx_half_q;
	logic [9:0]  idle_cnt_q;

	ucf_mem_if #(.W(11), .AW(AW)) rx_mem ();
	ucf_mem_if #(.W(8), .AW(AW))  tx_mem ();

	ucf_mem #(.W(11), .AW(AW)) u_rx_mem (.pclk(pclk), .presetn(presetn), .port(rx_mem));
	ucf_mem #(.W(8), .AW(AW))  u_tx_mem (.pclk(pclk), .presetn(presetn), .port(tx_mem));

	// Bus decode; every access completes in the cycle after its setup cycle.
	wire setup  = psel & ~penable;
	wire acc    = psel & penable & pready_q;
	wire wr_en  = acc & pwrite;
	wire rd_en  = acc & ~pwrite;
	wire a_data = paddr == `UCF_A_DATA;
	wire a_line = paddr == `UCF_A_LINE;
	wire a_fset = paddr == `UCF_A_FSET;
	wire a_pthr = paddr == `UCF_A_PTHR;
	wire a_flow = paddr == `UCF_A_FLOW;
	wire a_efr  = paddr == `UCF_A_EFR;
	wire a_div  = paddr == `UCF_A_DIV;
	wire a_mctl = paddr == `UCF_A_MCTL;
	wire a_stat = paddr == `UCF_A_STAT;
	wire hit    = a_data | a_line | a_fset | a_pthr | a_flow | a_efr | a_div | a_mctl | a_stat;

	// Configuration fields.
	wire [1:0] wl       = line_q[`UCF_LINE_WL];
	wire       par_en   = line_q[`UCF_LINE_PEN];
	wire       even     = line_q[`UCF_LINE_EVEN];
	wire       fifo_en  = fset_q[`UCF_FSET_EN];
	wire       auto_rts = efr_q[`UCF_EFR_RTS];
	wire       auto_cts = efr_q[`UCF_EFR_CTS];
	wire       prescale = mctl_q[`UCF_MCTL_PRE];
	wire       cts_act  = ~cts_n_f_q;
	wire [2:0] last_bit = 3'(3'h4 + 3'(wl));
	wire [CW-1:0] cap   = fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
	wire [CW-1:0] halt_lvl   = CW'({flow_q[`UCF_NIB_LO], 2'h0});
	wire [CW-1:0] resume_lvl = CW'({flow_q[`UCF_NIB_HI], 2'h0});
	wire [CW-1:0] rx_trig = trig_lvl(fifo_en, fset_q[`UCF_FSET_RXSEL], pthr_q[`UCF_NIB_HI], 1'b1);
	wire [CW-1:0] tx_trig = trig_lvl(fifo_en, fset_q[`UCF_FSET_TXSEL], pthr_q[`UCF_NIB_LO], 1'b0);
	wire rx_clr = wr_en & a_fset & pwdata[`UCF_FSET_RXCLR];
	wire tx_clr = wr_en & a_fset & pwdata[`UCF_FSET_TXCLR];

	// Baud timing: optional divide by four, then the divisor (zero acts as one).
	wire [15:0] div_eff = (div_q == 16'h0000) ? 16'h0001 : div_q;
	wire pre_tick = ~prescale | (pre_q == `UCF_PRE_LAST);
	wire tick     = pre_tick & (div_cnt_q >= 16'(div_eff - 16'h0001));

	// Receive side decode.
	wire rx_mid   = tick & (rx_sub_q == `UCF_VOTE_DONE);
	wire vote_win = tick & (rx_sub_q >= `UCF_VOTE_LO) & (rx_sub_q <= `UCF_VOTE_HI);
	wire rx_bitv  = maj3(vote_q);
	wire [7:0] rx_data = rx_sh_q >> (2'h3 - wl);
	wire rx_push  = rx_mid & (rx_st_q == RX_STOP);
	wire rx_full  = rx_cnt_q >= cap;
	wire rx_ferr  = ~rx_bitv;
	wire rx_brk   = rx_ferr & (rx_data == 8'h00);
	wire rx_pop   = rd_en & a_data & (rx_cnt_q != '0);
	wire idle_run = (rx_st_q == RX_IDLE) & rx_f_q;
	wire idle_set = idle_run & tick & (idle_cnt_q == `UCF_IDLE_LAST);

	// Transmit side decode.
	wire tx_bend  = tick & (tx_sub_q == `UCF_BIT_END);
	wire tx_hend  = tick & (tx_sub_q[2:0] == `UCF_HALF_END);
	wire [1:0] half_last = ~line_q[`UCF_LINE_STOP] ? `UCF_HALF_ONE :
		(wl == 2'h0) ? `UCF_HALF_ONEHALF : `UCF_HALF_TWO;
	wire [1:0] half_mid = 2'(half_last - 2'h1);
	wire cts_ok   = (tx_st_q == TX_IDLE) ? cts_act : tx_cts_q;
	wire tx_go    = (tx_cnt_q != '0) & ~tx_clr & (~auto_cts | cts_ok);
	wire tx_load  = (tx_st_d == TX_START) & (tx_st_q != TX_START);
	wire tx_full  = tx_cnt_q >= cap;
	wire tx_push  = wr_en & a_data & ~tx_full;
	wire [7:0] tx_word = tx_mem.rdata & (8'hFF >> (2'h3 - wl));
	wire txd_d = (tx_st_q == TX_START) ? 1'b0 : (tx_st_q == TX_DATA) ? tx_sh_q[0] :
		(tx_st_q == TX_PAR) ? tx_par_q : 1'b1;
	wire tx_dry   = (tx_st_q == TX_STOP) & (tx_st_d == TX_IDLE) & (tx_cnt_q == '0);

	// Queue pointers and the store ports.
	assign rx_mem.we    = rx_push & ~rx_full;
	assign rx_mem.waddr = rx_wp_q;
	assign rx_mem.wdata = {rx_brk, rx_ferr, rx_perr_q, rx_data};
	assign rx_mem.raddr = rx_clr ? '0 : AW'(rx_rp_q + AW'(rx_pop));
	assign tx_mem.we    = tx_push;
	assign tx_mem.waddr = tx_wp_q;
	assign tx_mem.wdata = pwdata[`UCF_ENT_DATA];
	assign tx_mem.raddr = tx_clr ? '0 : AW'(tx_rp_q + AW'(tx_load));

	// Sticky events; a clear removes only bits already reported, so a set wins.
	// Kept as a net so the change detector is re-evaluated whenever its inputs move.
	wire cts_chg = ~auto_cts & (cts_sy_q[2] == cts_sy_q[1]) & (cts_sy_q[2] != cts_n_f_q);
	wire [6:0] flag_set = {cts_chg, tx_dry, idle_set, rx_push & rx_brk,
		rx_push & rx_ferr, rx_push & rx_perr_q, rx_push & rx_full};
	wire [6:0] flag_clr = (rd_en & a_stat) ? prdata_q[`UCF_STAT_FLAGS] : 7'h00;

	wire ucf_word_t stat_w = (ucf_word_t'(tx_cnt_q) << `UCF_STAT_TXLVL) |
		(ucf_word_t'(rx_cnt_q) << `UCF_STAT_RXLVL) |
		ucf_word_t'({tx_cnt_q == '0, rx_cnt_q != '0, ~rts_n_q, cts_act, flags_q});
	wire ucf_word_t rd_mux = a_data ? ucf_word_t'(rx_mem.rdata) :
		a_line ? ucf_word_t'(line_q) : a_fset ? ucf_word_t'(fset_q) :
		a_pthr ? ucf_word_t'(pthr_q) : a_flow ? ucf_word_t'(flow_q) :
		a_efr ? ucf_word_t'(efr_q) : a_div ? ucf_word_t'(div_q) :
		a_mctl ? ucf_word_t'(mctl_q) : a_stat ? stat_w : '0;

	// Pin inputs settle through three stages before they are believed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sy_q   <= 3'h7;
			cts_sy_q  <= 3'h7;
			rx_f_q    <= 1'b1;
			cts_n_f_q <= 1'b1;
		end else begin
			rx_sy_q  <= {rx_sy_q[1:0], rxd};
			cts_sy_q <= {cts_sy_q[1:0], cts_n};
			if (rx_sy_q[1] == rx_sy_q[2]) rx_f_q <= rx_sy_q[2];
			if (cts_sy_q[1] == cts_sy_q[2]) cts_n_f_q <= cts_sy_q[2];
		end
	end

	// Bus answer is captured in the setup cycle and shown in the access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			prdata_q  <= (setup & ~pwrite) ? rd_mux : '0;
		end
	end

	// Software-written controls; queue reset bits act once and read back zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= `UCF_LINE_RST;
			fset_q <= `UCF_FSET_RST;
			pthr_q <= `UCF_THR_RST;
			flow_q <= `UCF_THR_RST;
			efr_q  <= `UCF_EFR_RST;
			div_q  <= `UCF_DIV_RST;
			mctl_q <= `UCF_MCTL_RST;
		end else if (wr_en) begin
			if (a_line) line_q <= pwdata[4:0];
			if (a_fset) fset_q <= pwdata[7:0] & `UCF_FSET_KEEP;
			if (a_pthr) pthr_q <= pwdata[7:0];
			if (a_flow) flow_q <= pwdata[7:0];
			if (a_efr) efr_q <= pwdata[7:0];
			if (a_div) div_q <= pwdata[15:0];
			if (a_mctl) mctl_q <= pwdata[7:0];
		end
	end

	// Baud counters, queue bookkeeping, status and the registered pins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q      <= 2'h0;
			div_cnt_q  <= 16'h0000;
			rx_wp_q    <= '0;
			rx_rp_q    <= '0;
			rx_cnt_q   <= '0;
			tx_wp_q    <= '0;
			tx_rp_q    <= '0;
			tx_cnt_q   <= '0;
			flags_q    <= 7'h00;
			idle_cnt_q <= 10'h000;
			rts_n_q    <= 1'b1;
			rx_dma_q   <= 1'b0;
			tx_dma_q   <= 1'b0;
		end else begin
			pre_q     <= 2'(pre_q + 2'h1);
			div_cnt_q <= tick ? 16'h0000 : 16'(div_cnt_q + 16'(pre_tick));
			rx_wp_q   <= rx_clr ? '0 : AW'(rx_wp_q + AW'(rx_mem.we));
			rx_rp_q   <= rx_mem.raddr;
			rx_cnt_q  <= rx_clr ? '0 : CW'(rx_cnt_q + CW'(rx_mem.we) - CW'(rx_pop));
			tx_wp_q   <= tx_clr ? '0 : AW'(tx_wp_q + AW'(tx_push));
			tx_rp_q   <= tx_mem.raddr;
			tx_cnt_q  <= tx_clr ? '0 : CW'(tx_cnt_q + CW'(tx_push) - CW'(tx_load));
			flags_q   <= (flags_q & ~flag_clr) | flag_set;
			idle_cnt_q <= ~idle_run ? 10'h000 :
				(tick && idle_cnt_q != `UCF_IDLE_LAST) ? 10'(idle_cnt_q + 10'h001) : idle_cnt_q;
			if (!auto_rts) rts_n_q <= ~mctl_q[`UCF_MCTL_RTS];
			else if (rx_cnt_q >= halt_lvl) rts_n_q <= 1'b1;
			else if (rx_cnt_q <= resume_lvl) rts_n_q <= 1'b0;
			rx_dma_q <= rx_cnt_q >= rx_trig;
			tx_dma_q <= CW'(cap - tx_cnt_q) >= tx_trig;
		end
	end

	// Receiver: a low line opens a start bit that must survive its own vote.
	always_comb begin
		rx_st_d = rx_st_q;
		case (rx_st_q)
			RX_IDLE:  if (!rx_f_q) rx_st_d = RX_START;
			RX_START: if (rx_mid) rx_st_d = rx_bitv ? RX_IDLE : RX_DATA;
			RX_DATA:  if (rx_mid && rx_bit_q == last_bit) rx_st_d = par_en ? RX_PAR : RX_STOP;
			RX_PAR:   if (rx_mid) rx_st_d = RX_STOP;
			RX_STOP:  if (rx_mid) rx_st_d = RX_IDLE;
			default:  rx_st_d = RX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q   <= RX_IDLE;
			rx_sub_q  <= 4'h0;
			rx_bit_q  <= 3'h0;
			vote_q    <= 3'h7;
			rx_sh_q   <= 8'h00;
			rx_perr_q <= 1'b0;
		end else begin
			rx_st_q  <= rx_st_d;
			rx_sub_q <= (rx_st_q == RX_IDLE) ? 4'h0 : 4'(rx_sub_q + 4'(tick));
			rx_bit_q <= (rx_st_q != RX_DATA) ? 3'h0 : 3'(rx_bit_q + 3'(rx_mid));
			if (vote_win) vote_q <= {vote_q[1:0], rx_f_q};
			if (rx_mid && rx_st_q == RX_DATA) rx_sh_q <= {rx_bitv, rx_sh_q[7:1]};
			if (rx_st_q == RX_IDLE) rx_perr_q <= 1'b0;
			else if (rx_mid && rx_st_q == RX_PAR) rx_perr_q <= rx_bitv != par_of(rx_data, even);
		end
	end

	// Transmitter: CTS is read half a bit before the stop bits end for back-to-back
	// characters, and live when the line has gone idle.
	always_comb begin
		tx_st_d = tx_st_q;
		case (tx_st_q)
			TX_IDLE:  if (tx_go) tx_st_d = TX_START;
			TX_START: if (tx_bend) tx_st_d = TX_DATA;
			TX_DATA:  if (tx_bend && tx_bit_q == last_bit) tx_st_d = par_en ? TX_PAR : TX_STOP;
			TX_PAR:   if (tx_bend) tx_st_d = TX_STOP;
			TX_STOP:  if (tx_hend && tx_half_q == half_last) tx_st_d = tx_go ? TX_START : TX_IDLE;
			default:  tx_st_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q   <= TX_IDLE;
			tx_sub_q  <= 4'h0;
			tx_bit_q  <= 3'h0;
			tx_half_q <= 2'h0;
			tx_sh_q   <= 8'h00;
			tx_par_q  <= 1'b0;
			tx_cts_q  <= 1'b0;
			txd_q     <= 1'b1;
		end else begin
			tx_st_q   <= tx_st_d;
			tx_sub_q  <= (tx_st_d != tx_st_q) ? 4'h0 : 4'(tx_sub_q + 4'(tick));
			tx_bit_q  <= (tx_st_q != TX_DATA) ? 3'h0 : 3'(tx_bit_q + 3'(tx_bend));
			tx_half_q <= (tx_st_q != TX_STOP) ? 2'h0 : 2'(tx_half_q + 2'(tx_hend));
			if (tx_load) begin
				tx_sh_q  <= tx_word;
				tx_par_q <= par_of(tx_word, even);
			end else if (tx_bend && tx_st_q == TX_DATA) begin
				tx_sh_q <= {1'b0, tx_sh_q[7:1]};
			end
			if (tx_st_q == TX_IDLE || (tx_hend && tx_st_q == TX_STOP && tx_half_q == half_mid))
				tx_cts_q <= cts_act;
			txd_q <= txd_d;
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign txd            = txd_q;
	assign rts_n          = rts_n_q;
	assign rx_dma_request = rx_dma_q;
	assign tx_dma_request = tx_dma_q;

	// Checks on the channel's own behaviour.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RX_DEPTH: assert property (rx_cnt_q <= CW'(FIFO_DEPTH))
		else $error("Receive fill above depth.");
	AST_PRESCALE: assert property (prescale && pre_tick |=>
		(!prescale || !pre_tick) [*3] ##1 (!prescale || pre_tick))
		else $error("Prescaler not dividing by four.");
	AST_VOTE: assert property (rx_mid && rx_st_q == RX_START && $countones(vote_q) == 1
		|=> rx_st_q == RX_DATA)
		else $error("Majority low start bit rejected.");
	AST_TRIG_ONE: assert property (!fifo_en && rx_cnt_q != '0 |=> rx_dma_q)
		else $error("Receive request missing with one character held.");
	AST_TX_REQ: assert property (tx_cnt_q == '0 |=> tx_dma_q)
		else $error("Transmit request missing with empty queue.");
	AST_CTS_GATE: assert property (tx_st_q == TX_IDLE && auto_cts && !cts_act
		|=> tx_st_q == TX_IDLE)
		else $error("Character started while CTS inactive.");
	AST_RTS_HALT: assert property (auto_rts && rx_cnt_q >= halt_lvl |=> rts_n_q)
		else $error("RTS still active at halt level.");
	AST_RTS_RESUME: assert property (auto_rts && rx_cnt_q <= resume_lvl
		&& rx_cnt_q < halt_lvl |=> !rts_n_q)
		else $error("RTS not restored at resume level.");
	AST_NO_LOSS: assert property (rx_push && !rx_full && !rx_pop && !rx_clr
		|=> rx_cnt_q == CW'($past(rx_cnt_q) + CW'(1)))
		else $error("Received character not stored.");
	AST_SEND_ANY: assert property (!auto_cts && tx_st_q == TX_IDLE && tx_cnt_q != '0
		&& !tx_clr |=> tx_st_q == TX_START)
		else $error("Queued character not sent without auto CTS.");
	AST_UNDERFLOW: assert property (tx_dry |=> flags_q[`UCF_STAT_UNDR])
		else $error("Transmit dry event not flagged.");
	AST_IDLE_MARK: assert property (tx_st_q == TX_IDLE [*2] |-> txd_q)
		else $error("Serial output not at mark while idle.");

	COV_RX_CHAR: cover property (rx_push && !rx_full);
	COV_BACK2BACK: cover property (tx_st_q == TX_STOP && tx_st_d == TX_START);
	COV_RTS_DROP: cover property (auto_rts && !rts_n_q ##1 rts_n_q);
endmodule

// ===== logic/ucf_map.svh
`ifndef UCF_MAP_SVH
`define UCF_MAP_SVH

// Storage depth of each character queue.
`define UCF_FIFO_DEPTH   64

// Register byte addresses on the peripheral bus.
`define UCF_A_DATA       8'h00
`define UCF_A_LINE       8'h04
`define UCF_A_FSET       8'h08
`define UCF_A_PTHR       8'h0C
`define UCF_A_FLOW       8'h10
`define UCF_A_EFR        8'h14
`define UCF_A_DIV        8'h18
`define UCF_A_MCTL       8'h1C
`define UCF_A_STAT       8'h20

// Reset values.
`define UCF_LINE_RST     5'h00
`define UCF_FSET_RST     8'h00
`define UCF_THR_RST      8'h00
`define UCF_EFR_RST      8'h00
`define UCF_DIV_RST      16'h0001
`define UCF_MCTL_RST     8'h00

// Field positions.
`define UCF_LINE_WL      1:0
`define UCF_LINE_STOP    2
`define UCF_LINE_PEN     3
`define UCF_LINE_EVEN    4
`define UCF_FSET_EN      0
`define UCF_FSET_RXCLR   1
`define UCF_FSET_TXCLR   2
`define UCF_FSET_TXSEL   5:4
`define UCF_FSET_RXSEL   7:6
`define UCF_FSET_KEEP    8'hF9
`define UCF_NIB_LO       3:0
`define UCF_NIB_HI       7:4
`define UCF_EFR_RTS      6
`define UCF_EFR_CTS      7
`define UCF_MCTL_RTS     0
`define UCF_MCTL_PRE     7
`define UCF_ENT_DATA     7:0
`define UCF_ENT_PERR     8
`define UCF_ENT_FERR     9
`define UCF_ENT_BRK      10
`define UCF_STAT_FLAGS   6:0
`define UCF_STAT_OVR     0
`define UCF_STAT_PERR    1
`define UCF_STAT_FERR    2
`define UCF_STAT_BRK     3
`define UCF_STAT_IDLE    4
`define UCF_STAT_UNDR    5
`define UCF_STAT_CTSC    6
`define UCF_STAT_RXLVL   16
`define UCF_STAT_TXLVL   24

// Sixteen-times oversampling points within one bit, then the idle, stop-length and prescale counts.
`define UCF_VOTE_LO      4'h7
`define UCF_VOTE_HI      4'h9
`define UCF_VOTE_DONE    4'hA
`define UCF_BIT_END      4'hF
`define UCF_HALF_END     3'h7
`define UCF_IDLE_LAST    10'h27F
`define UCF_HALF_ONE     2'h1
`define UCF_HALF_ONEHALF 2'h2
`define UCF_HALF_TWO     2'h3
`define UCF_PRE_LAST     2'h3

// Selectable trigger levels in characters.
`define UCF_RX_TRIG0     7'h08
`define UCF_RX_TRIG1     7'h10
`define UCF_RX_TRIG2     7'h38
`define UCF_RX_TRIG3     7'h3C
`define UCF_TX_TRIG0     7'h08
`define UCF_TX_TRIG1     7'h10
`define UCF_TX_TRIG2     7'h20
`define UCF_TX_TRIG3     7'h38

`endif

// ===== logic/ucf_mem.sv
`timescale 1ns/10ps
module ucf_mem #(
	parameter int W  = 11,
	parameter int AW = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	ucf_mem_if.mem   port
);
	import ucf_pkg::*;

	logic [W-1:0] store [2**AW];
	logic [W-1:0] rdata_q;

	// The array has no reset, so it can map onto plain storage cells.
	always_ff @(posedge pclk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// A write to the address being read is passed straight through, so a
	// character pushed into an empty queue is visible one edge later.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
		end else if (port.we && port.waddr == port.raddr) begin
			rdata_q <= port.wdata;
		end else begin
			rdata_q <= store[port.raddr];
		end
	end

	assign port.rdata = rdata_q;
endmodule

// ===== logic/ucf_mem_if.sv
`timescale 1ns/10ps
// Write and read port of one character store.
interface ucf_mem_if #(
	parameter int W  = 11,
	parameter int AW = 6
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [W-1:0]  wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0]  rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== logic/ucf_pkg.sv
package ucf_pkg;
	typedef logic [31:0] ucf_word_t;
	typedef logic [7:0]  ucf_addr_t;
	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} ucf_rx_st_t;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_PAR   = 5'h08,
		TX_STOP  = 5'h10
	} ucf_tx_st_t;
endpackage

// ===== test/uart_channel_fifo_autoflow_tb_top.sv
`timescale 1ns/10ps
`include "ucf_map.svh"
module uart_channel_fifo_autoflow_tb_top;
	import ucf_pkg::*;
	logic      pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic      rxd, txd, cts_n, rts_n, rx_dma_request, tx_dma_request;
	ucf_addr_t paddr;
	ucf_word_t pwdata, prdata;
	logic [7:0] m;
	ucf_word_t rv;
	logic      ev;
	int        bad_count = 0;
	int        num_checks = 0;
	ucf_channel ucf_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.cts_n(cts_n), .rts_n(rts_n), .rx_dma_request(rx_dma_request),
		.tx_dma_request(tx_dma_request));
	ucf_remote ucf_remote_i (.pclk(pclk), .txd(txd), .rxd(rxd));
	task automatic check(input ucf_word_t seen, input ucf_word_t exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %08h expected %08h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One APB transfer; an idle edge follows so back-to-back calls never collide.
	task automatic apb(input logic w, input ucf_addr_t a, input ucf_word_t d,
			output ucf_word_t r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits for the answer however long it takes; only the watchdog ends a hang.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input ucf_addr_t a, input ucf_word_t d);
		ucf_word_t r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rc(input ucf_addr_t a, input ucf_word_t mk, input ucf_word_t x);
		ucf_word_t r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r & mk, x);
		check({31'h0, e}, 32'h0);
	endtask
	task automatic bit1(input logic s, input logic x);
		check({31'h0, s}, {31'h0, x});
	endtask
	// Waits a bounded time for the far end to decode a character.
	task automatic wait_tx(input logic [7:0] x);
		int n;
		n = 0;
		while (ucf_remote_i.got_q.size() == 0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n == 400) begin
			ucf_remote_i.got_q.push_back(8'hXX);
		end
		check({24'h0, ucf_remote_i.got_q.pop_front()}, {24'h0, x});
		repeat (32) @(posedge pclk);
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// The watchdog is far above the few thousand cycles the sequence needs.
	initial begin
		repeat (50000) @(posedge pclk);
		bad_count++;
		wrap_up();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		cts_n = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		bit1(tx_dma_request, 1'b1);
		bit1(rx_dma_request, 1'b0);
		rc(`UCF_A_FSET, 32'hFFFFFFFF, 32'h0);
		rc(`UCF_A_DIV, 32'hFFFFFFFF, 32'h1);
		rc(`UCF_A_STAT, 32'hFFFFFFFF, 32'h400);
		apb(1'b0, 8'h24, 32'h0, rv, ev);
		check(rv, 32'h0);
		check({31'h0, ev}, 32'h1);
		for (int w = 0; w < 4; w++) begin
			m = 8'hFF << (w + 5);
			wr(`UCF_A_LINE, w);
			wr(`UCF_A_DATA, 32'h55);
			wait_tx(8'h55 | m);
		end
		// Seven bits with even parity: the eighth sample is the parity bit, not the stop.
		wr(`UCF_A_LINE, 32'h1A);
		wr(`UCF_A_DATA, 32'h55);
		wait_tx(8'h55);
		wr(`UCF_A_LINE, 32'h3);
		ucf_remote_i.send(8'h3C, 1'b1, 1'b1);
		rc(`UCF_A_DATA, 32'h7FF, 32'h3C);
		ucf_remote_i.send(8'h00, 1'b0, 1'b0);
		rc(`UCF_A_DATA, 32'h7FF, 32'h600);
		ucf_remote_i.send(8'h11, 1'b1, 1'b0);
		ucf_remote_i.send(8'h22, 1'b1, 1'b0);
		rc(`UCF_A_STAT, 32'h1F, 32'h1D);
		rc(`UCF_A_DATA, 32'h7FF, 32'h11);
		wr(`UCF_A_EFR, 32'h80);
		wr(`UCF_A_DATA, 32'h5A);
		m = 8'h0;
		repeat (320) begin
			@(posedge pclk);
			m = m | {7'h0, ~txd};
		end
		check({24'h0, m}, 32'h0);
		rc(`UCF_A_STAT, 32'h7F000000, 32'h01000000);
		cts_n <= 1'b0;
		wait_tx(8'h5A);
		wr(`UCF_A_FSET, 32'h1);
		wr(`UCF_A_FLOW, 32'h1);
		wr(`UCF_A_PTHR, 32'h10);
		wr(`UCF_A_EFR, 32'hC0);
		for (int i = 0; i < 4; i++) begin
			ucf_remote_i.send(8'h40 + i, 1'b1, 1'b0);
			bit1(rts_n, i > 2);
			bit1(rx_dma_request, i > 2);
		end
		ucf_remote_i.send(8'h44, 1'b1, 1'b0);
		rc(`UCF_A_STAT, 32'h7F0040, 32'h50000);
		for (int i = 0; i < 5; i++) begin
			rc(`UCF_A_DATA, 32'h7FF, 32'h40 + i);
		end
		// The pins follow the fill one edge after the last pop, so let that edge pass.
		@(posedge pclk);
		bit1(rts_n, 1'b0);
		bit1(rx_dma_request, 1'b0);
		cts_n <= 1'b1;
		repeat (8) @(posedge pclk);
		repeat (65) wr(`UCF_A_DATA, 32'h33);
		rc(`UCF_A_STAT, 32'h7F000000, 32'h40000000);
		bit1(tx_dma_request, 1'b0);
		wr(`UCF_A_FSET, 32'h5);
		rc(`UCF_A_STAT, 32'h7F000000, 32'h0);
		wr(`UCF_A_MCTL, 32'h80);
		rc(`UCF_A_MCTL, 32'hFF, 32'h80);
		repeat (16) @(posedge pclk);
		wrap_up();
	end
endmodule

// ===== test/ucf_remote.sv
`timescale 1ns/10ps
// Far-end serial device: frames 8-bit characters onto rxd and decodes txd.
module ucf_remote #(
	parameter int BIT_CYC = 16
) (
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial rxd = 1'b1;
	// Sends a frame; the optional two-cycle glitch outlasts the pin filter and spoils
	// only the first vote sample of each bit, which the majority must outvote.
	task automatic send(input logic [7:0] ch, input logic stp, input logic glitch);
		logic [9:0] fr;
		fr = {stp, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= fr[i];
			repeat (BIT_CYC / 2 - 1) @(posedge pclk);
			if (glitch) begin
				rxd <= ~fr[i];
			end
			repeat (2) @(posedge pclk);
			rxd <= fr[i];
			repeat (BIT_CYC / 2 - 1) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (BIT_CYC) @(posedge pclk);
	endtask
	// Samples eight bits at mid-bit; short words read the stop and idle ones.
	always begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge pclk);
			sh[i] = txd;
		end
		got_q.push_back(sh);
	end
endmodule
